/* core/scos_pkg.sv */
package scos_pkg;
    // ======================================================================
    // widths
    localparam int SEL_W = 8;
    localparam int SPD_W = 16;
    localparam int NUM_OUT = 3;

    // ======================================================================
    // function codes
    localparam logic [7:0] FN_RUN = 8'h00;
    localparam logic [7:0] FN_ZERO_SPD = 8'h01;
    localparam logic [7:0] FN_READY = 8'h06;
    localparam logic [7:0] FN_UNDERVOLT = 8'h07;
    localparam logic [7:0] FN_BLOCKED = 8'h08;
    localparam logic [7:0] FN_REF_LOCAL = 8'h09;
    localparam logic [7:0] FN_CMD_LOCAL = 8'h0A;
    localparam logic [7:0] FN_FAULT = 8'h0E;
    localparam logic [7:0] FN_MINOR = 8'h10;
    localparam logic [7:0] FN_FLT_RESET = 8'h11;
    localparam logic [7:0] FN_REVERSE = 8'h1A;
    localparam logic [7:0] FN_EXT_BLOCK = 8'h1B;
    localparam logic [7:0] FN_REGEN = 8'h1D;
    localparam logic [7:0] FN_DOOR_ZONE = 8'h42;
    localparam logic [7:0] FN_NOT_ZERO = 8'h43;

    // ======================================================================
    // register map (word aligned byte offsets)
    localparam logic [7:0] OFS_SEL1 = 8'h00;
    localparam logic [7:0] OFS_SEL2 = 8'h04;
    localparam logic [7:0] OFS_SEL3 = 8'h08;
    localparam logic [7:0] OFS_ZERO_THR = 8'h0C;
    localparam logic [7:0] OFS_DOOR_THR = 8'h10;
    localparam logic [7:0] OFS_CTRL = 8'h14;
    localparam logic [7:0] OFS_STATUS = 8'h18;

    // ======================================================================
    // reset values
    localparam logic [7:0] RST_SEL1 = 8'h40;
    localparam logic [7:0] RST_SEL2 = 8'h41;
    localparam logic [7:0] RST_SEL3 = 8'h06;
    localparam logic [15:0] RST_ZERO_THR = 16'h0000;
    localparam logic [15:0] RST_DOOR_THR = 16'h0000;
    localparam logic RST_CLOSED_LOOP = 1'b0;

    // ======================================================================
    // control field
    localparam int CTRL_CLOSED_LOOP_BIT = 0;
endpackage : scos_pkg

/* core/scos_cond_if.sv */
`timescale 1ns/1ps
interface scos_cond_if;
    logic [scos_pkg::SPD_W-1:0] zero_speed_threshold;
    logic [scos_pkg::SPD_W-1:0] door_zone_speed_threshold;
    logic closed_loop;
    logic run_cmd;
    logic out_voltage;
    logic [scos_pkg::SPD_W-1:0] out_freq;
    logic [scos_pkg::SPD_W-1:0] motor_speed;
    logic decelerating;
    logic travel_cmd;
    logic init_done;
    logic major_fault;
    logic processor_comm_fault_a;
    logic processor_comm_fault_b;
    logic minor_fault;
    logic fault_reset_cmd;
    logic reverse_cmd;
    logic dc_bus_undervoltage;
    logic output_blocked;
    logic ref_src_local;
    logic cmd_src_local;
    logic external_block_input;
    logic regenerating;
    modport src (
        output zero_speed_threshold, door_zone_speed_threshold, closed_loop,
        output run_cmd, out_voltage, out_freq, motor_speed, decelerating,
        output travel_cmd, init_done, major_fault, processor_comm_fault_a,
        output processor_comm_fault_b, minor_fault, fault_reset_cmd,
        output reverse_cmd, dc_bus_undervoltage, output_blocked,
        output ref_src_local, cmd_src_local, external_block_input,
        output regenerating
    );
    modport sink (
        input zero_speed_threshold, door_zone_speed_threshold, closed_loop,
        input run_cmd, out_voltage, out_freq, motor_speed, decelerating,
        input travel_cmd, init_done, major_fault, processor_comm_fault_a,
        input processor_comm_fault_b, minor_fault, fault_reset_cmd,
        input reverse_cmd, dc_bus_undervoltage, output_blocked,
        input ref_src_local, cmd_src_local, external_block_input,
        input regenerating
    );
endinterface : scos_cond_if

/* core/scos_selector.sv */
`timescale 1ns/1ps
module scos_selector (
    input wire logic clock,
    input wire logic srst,
    scos_cond_if.sink cond,
    input wire logic [scos_pkg::SEL_W-1:0] sel,
    output logic contact_q
);
    // ======================================================================
    // status conditions
    wire zero_spd = cond.out_freq < cond.zero_speed_threshold;
    wire not_zero = cond.out_freq > cond.zero_speed_threshold;
    wire [scos_pkg::SPD_W-1:0] dz_speed =
        cond.closed_loop ? cond.motor_speed : cond.out_freq;
    wire door_zone = cond.travel_cmd && cond.decelerating &&
        (dz_speed > cond.door_zone_speed_threshold);
    wire fault_sel = cond.major_fault && !cond.processor_comm_fault_a &&
        !cond.processor_comm_fault_b;
    wire run_on = cond.run_cmd || cond.out_voltage;
    wire ready_on = cond.init_done && !cond.major_fault;
    wire block_off = !cond.external_block_input;
    logic contact_d;

    // ======================================================================
    // selection
    always_comb begin
        case (sel)
            scos_pkg::FN_RUN: contact_d = run_on;
            scos_pkg::FN_ZERO_SPD: begin
                if (zero_spd) contact_d = 1'b1;
                else if (not_zero) contact_d = 1'b0;
                else contact_d = contact_q;
            end
            scos_pkg::FN_READY: contact_d = ready_on;
            scos_pkg::FN_UNDERVOLT: contact_d = cond.dc_bus_undervoltage;
            scos_pkg::FN_BLOCKED: contact_d = cond.output_blocked;
            scos_pkg::FN_REF_LOCAL: contact_d = cond.ref_src_local;
            scos_pkg::FN_CMD_LOCAL: contact_d = cond.cmd_src_local;
            scos_pkg::FN_FAULT: contact_d = fault_sel;
            scos_pkg::FN_MINOR: contact_d = cond.minor_fault;
            scos_pkg::FN_FLT_RESET: contact_d = cond.fault_reset_cmd;
            scos_pkg::FN_REVERSE: contact_d = cond.reverse_cmd;
            scos_pkg::FN_EXT_BLOCK: contact_d = block_off;
            scos_pkg::FN_REGEN: contact_d = cond.regenerating;
            scos_pkg::FN_DOOR_ZONE: contact_d = door_zone;
            scos_pkg::FN_NOT_ZERO: begin
                if (not_zero) contact_d = 1'b1;
                else if (zero_spd) contact_d = 1'b0;
                else contact_d = contact_q;
            end
            default: contact_d = 1'b0;
        endcase
    end

    always_ff @(posedge clock) begin
        if (srst) begin
            contact_q <= 1'b0;
        end else begin
            contact_q <= contact_d;
        end
    end
endmodule : scos_selector

/* core/scos_top.sv */
// Summary of operation
// - three contact outputs, each with function select
// - run code: on while run or voltage
// - zero speed: on below threshold, off above
// - ready code: on after fault-free initialization
// - undervoltage code: on while bus undervoltage
// - blocked code: on while output stage blocked
// - reference source code: on when panel selected
// - command source code: on when panel selected
// - fault code: major faults except comm faults
// - minor fault code: on during alarm
// - fault reset code: on during reset command
// - reverse code: on while reverse command active
// - external block code: off while block input
// - regeneration code: on while motor regenerating
// - door zone: decelerating speed above threshold
// - door zone: off when travel command released
// - not zero speed: on above threshold, off below, holds at threshold
`timescale 1ns/1ps
module scos_top (
    input wire logic clock,
    input wire logic srst,
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [7:0] wb_adr_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    output logic [31:0] wb_dat_o,
    output logic wb_ack_o,
    input wire logic run_cmd,
    input wire logic out_voltage,
    input wire logic [15:0] out_freq,
    input wire logic [15:0] motor_speed,
    input wire logic decelerating,
    input wire logic travel_cmd,
    input wire logic init_done,
    input wire logic major_fault,
    input wire logic processor_comm_fault_a,
    input wire logic processor_comm_fault_b,
    input wire logic minor_fault,
    input wire logic fault_reset_cmd,
    input wire logic reverse_cmd,
    input wire logic dc_bus_undervoltage,
    input wire logic output_blocked,
    input wire logic ref_src_local,
    input wire logic cmd_src_local,
    input wire logic external_block_input,
    input wire logic regenerating,
    output logic [2:0] contact_out
);
    // ======================================================================
    // registers
    logic [7:0] sel1_q;
    logic [7:0] sel2_q;
    logic [7:0] sel3_q;
    logic [15:0] zero_thr_q;
    logic [15:0] door_thr_q;
    logic closed_loop_q;
    logic ack_q;
    logic [31:0] rdata_q;

    // ======================================================================
    // wishbone decode
    wire req = wb_cyc_i && wb_stb_i && !ack_q;
    wire wr = req && wb_we_i;
    wire hit_sel1 = wb_adr_i == scos_pkg::OFS_SEL1;
    wire hit_sel2 = wb_adr_i == scos_pkg::OFS_SEL2;
    wire hit_sel3 = wb_adr_i == scos_pkg::OFS_SEL3;
    wire hit_zthr = wb_adr_i == scos_pkg::OFS_ZERO_THR;
    wire hit_dthr = wb_adr_i == scos_pkg::OFS_DOOR_THR;
    wire hit_ctrl = wb_adr_i == scos_pkg::OFS_CTRL;
    wire hit_stat = wb_adr_i == scos_pkg::OFS_STATUS;
    wire [15:0] thr_wr_z = {wb_sel_i[1] ? wb_dat_i[15:8] : zero_thr_q[15:8],
        wb_sel_i[0] ? wb_dat_i[7:0] : zero_thr_q[7:0]};
    wire [15:0] thr_wr_d = {wb_sel_i[1] ? wb_dat_i[15:8] : door_thr_q[15:8],
        wb_sel_i[0] ? wb_dat_i[7:0] : door_thr_q[7:0]};
    wire lo_en = wb_sel_i[0];
    logic [31:0] rdata_d;

    always_comb begin
        rdata_d = 32'h0000_0000;
        if (hit_sel1) rdata_d = {24'h00_0000, sel1_q};
        else if (hit_sel2) rdata_d = {24'h00_0000, sel2_q};
        else if (hit_sel3) rdata_d = {24'h00_0000, sel3_q};
        else if (hit_zthr) rdata_d = {16'h0000, zero_thr_q};
        else if (hit_dthr) rdata_d = {16'h0000, door_thr_q};
        else if (hit_ctrl) rdata_d = {31'h0000_0000, closed_loop_q};
        else if (hit_stat) rdata_d = {29'h0000_0000, contact_out};
    end

    always_ff @(posedge clock) begin
        if (srst) begin
            ack_q <= 1'b0;
            rdata_q <= 32'h0000_0000;
        end else begin
            ack_q <= req;
            rdata_q <= rdata_d;
        end
    end

    always_ff @(posedge clock) begin
        if (srst) begin
            sel1_q <= scos_pkg::RST_SEL1;
            sel2_q <= scos_pkg::RST_SEL2;
            sel3_q <= scos_pkg::RST_SEL3;
        end else if (wr && lo_en) begin
            if (hit_sel1) sel1_q <= wb_dat_i[7:0];
            if (hit_sel2) sel2_q <= wb_dat_i[7:0];
            if (hit_sel3) sel3_q <= wb_dat_i[7:0];
        end
    end

    always_ff @(posedge clock) begin
        if (srst) begin
            zero_thr_q <= scos_pkg::RST_ZERO_THR;
            door_thr_q <= scos_pkg::RST_DOOR_THR;
            closed_loop_q <= scos_pkg::RST_CLOSED_LOOP;
        end else if (wr) begin
            if (hit_zthr) zero_thr_q <= thr_wr_z;
            if (hit_dthr) door_thr_q <= thr_wr_d;
            if (hit_ctrl && lo_en) begin
                closed_loop_q <= wb_dat_i[scos_pkg::CTRL_CLOSED_LOOP_BIT];
            end
        end
    end

    assign wb_ack_o = ack_q;
    assign wb_dat_o = rdata_q;

    // ======================================================================
    // condition bundle
    scos_cond_if cond ();
    assign cond.zero_speed_threshold = zero_thr_q;
    assign cond.door_zone_speed_threshold = door_thr_q;
    assign cond.closed_loop = closed_loop_q;
    assign cond.run_cmd = run_cmd;
    assign cond.out_voltage = out_voltage;
    assign cond.out_freq = out_freq;
    assign cond.motor_speed = motor_speed;
    assign cond.decelerating = decelerating;
    assign cond.travel_cmd = travel_cmd;
    assign cond.init_done = init_done;
    assign cond.major_fault = major_fault;
    assign cond.processor_comm_fault_a = processor_comm_fault_a;
    assign cond.processor_comm_fault_b = processor_comm_fault_b;
    assign cond.minor_fault = minor_fault;
    assign cond.fault_reset_cmd = fault_reset_cmd;
    assign cond.reverse_cmd = reverse_cmd;
    assign cond.dc_bus_undervoltage = dc_bus_undervoltage;
    assign cond.output_blocked = output_blocked;
    assign cond.ref_src_local = ref_src_local;
    assign cond.cmd_src_local = cmd_src_local;
    assign cond.external_block_input = external_block_input;
    assign cond.regenerating = regenerating;

    // ======================================================================
    // contact outputs
    wire [7:0] sel_arr [3];
    assign sel_arr[0] = sel1_q;
    assign sel_arr[1] = sel2_q;
    assign sel_arr[2] = sel3_q;

    genvar gi;
    generate
        for (gi = 0; gi < scos_pkg::NUM_OUT; gi++) begin : g_out
            scos_selector u_sel (
                .clock(clock),
                .srst(srst),
                .cond(cond),
                .sel(sel_arr[gi]),
                .contact_q(contact_out[gi])
            );
        end
    endgenerate
endmodule : scos_top

/* testbench/scos_lift_ctrl.sv */
`timescale 1ns/1ps
// ==============================
// lift controller reading contacts
module scos_lift_ctrl (
    input wire logic clock,
    input wire logic [2:0] contacts,
    output logic [2:0] seen_q
);
    always_ff @(posedge clock) begin
        seen_q <= contacts;
    end
endmodule : scos_lift_ctrl

/* testbench/scos_top_properties.sv */
`timescale 1ns/1ps
module scos_top_properties (
    input wire logic clock,
    input wire logic srst,
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [7:0] wb_adr_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    input wire logic wb_ack_o,
    input wire logic run_cmd,
    input wire logic out_voltage,
    input wire logic major_fault,
    input wire logic processor_comm_fault_a,
    input wire logic processor_comm_fault_b,
    input wire logic dc_bus_undervoltage,
    input wire logic reverse_cmd,
    input wire logic external_block_input,
    input wire logic travel_cmd,
    input wire logic [2:0] contact_out
);
    // ==============================
    // shadow of output 3 select
    logic [7:0] s3_q;
    logic [1:0] live_q;
    wire wr3 = wb_cyc_i && wb_stb_i && wb_we_i && !wb_ack_o
        && wb_sel_i[0] && wb_adr_i == scos_pkg::OFS_SEL3;
    wire c3 = contact_out[2];
    always_ff @(posedge clock) begin
        if (srst) begin
            s3_q <= scos_pkg::RST_SEL3;
            live_q <= 2'h0;
        end else begin
            live_q <= {live_q[0], 1'b1};
            if (wr3) begin
                s3_q <= wb_dat_i[7:0];
            end
        end
    end
    default clocking cb @(posedge clock); endclocking
    default disable iff (srst);
    sequence s_take;
        wb_cyc_i && wb_stb_i && !wb_ack_o;
    endsequence
    sequence s_fn(logic [7:0] f);
        live_q[1] && $past(s3_q) == f;
    endsequence
    a_ack_one_cycle: assert property (s_take |=> wb_ack_o)
        else $error("ack late");
    a_ack_pulse: assert property (wb_ack_o |=> !wb_ack_o)
        else $error("ack held");
    a_run_or_volt: assert property (s_fn(scos_pkg::FN_RUN)
        |-> c3 == ($past(run_cmd) || $past(out_voltage)))
        else $error("run output wrong");
    a_uv_follow: assert property (s_fn(scos_pkg::FN_UNDERVOLT)
        |-> c3 == $past(dc_bus_undervoltage)) else $error("uv wrong");
    a_fault_mask: assert property (s_fn(scos_pkg::FN_FAULT)
        |-> c3 == ($past(major_fault) && !$past(processor_comm_fault_a)
        && !$past(processor_comm_fault_b))) else $error("fault wrong");
    a_reverse_follow: assert property (s_fn(scos_pkg::FN_REVERSE)
        |-> c3 == $past(reverse_cmd)) else $error("reverse wrong");
    a_block_inverted: assert property (s_fn(scos_pkg::FN_EXT_BLOCK)
        |-> c3 != $past(external_block_input)) else $error("block wrong");
    a_door_release: assert property (live_q[1]
        && $past(s3_q) == scos_pkg::FN_DOOR_ZONE && !$past(travel_cmd)
        |-> !c3) else $error("door zone on without travel");
    a_undef_off: assert property (s_fn(8'h05) |-> !c3)
        else $error("undefined code drives output");
endmodule : scos_top_properties
bind scos_top scos_top_properties u_props (.clock, .srst, .wb_cyc_i,
    .wb_stb_i, .wb_we_i, .wb_adr_i, .wb_sel_i, .wb_dat_i, .wb_ack_o,
    .run_cmd, .out_voltage, .major_fault, .processor_comm_fault_a,
    .processor_comm_fault_b, .dc_bus_undervoltage, .reverse_cmd,
    .external_block_input, .travel_cmd, .contact_out);

/* testbench/scos_tb_top.sv */
`timescale 1ns/1ps
module scos_tb_top;
    logic clock, srst, wb_cyc_i, wb_stb_i, wb_we_i, wb_ack_o;
    logic [3:0] wb_sel_i, lanes;
    logic [7:0] wb_adr_i;
    logic [31:0] wb_dat_i, wb_dat_o, rq;
    logic [15:0] out_freq, motor_speed;
    logic [16:0] fl;
    logic [2:0] contact_out, seen;
    int n_fail, comparisons;
    scos_top dut (.clock, .srst, .wb_cyc_i, .wb_stb_i, .wb_we_i,
        .wb_adr_i, .wb_sel_i, .wb_dat_i, .wb_dat_o, .wb_ack_o,
        .run_cmd(fl[0]), .out_voltage(fl[1]), .out_freq, .motor_speed,
        .decelerating(fl[2]), .travel_cmd(fl[3]), .init_done(fl[4]),
        .major_fault(fl[5]), .processor_comm_fault_a(fl[6]),
        .processor_comm_fault_b(fl[7]), .minor_fault(fl[8]),
        .fault_reset_cmd(fl[9]), .reverse_cmd(fl[10]),
        .dc_bus_undervoltage(fl[11]), .output_blocked(fl[12]),
        .ref_src_local(fl[13]), .cmd_src_local(fl[14]),
        .external_block_input(fl[15]), .regenerating(fl[16]),
        .contact_out);
    scos_lift_ctrl u_ctrl (.clock, .contacts(contact_out), .seen_q(seen));
    // ==============================
    // bench tasks
    initial begin
        clock = 1'b0;
        forever #50 clock = ~clock;
    end
    task automatic wrap_up;
        $display("comparisons %0d mismatches %0d", comparisons, n_fail);
        if (n_fail == 0 && comparisons > 0) $display("Simulation passed");
        else $display("Simulation failed");
        $finish;
    endtask : wrap_up
    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        comparisons++;
        if (got !== exp) begin
            n_fail++;
            $display("MISMATCH at %0t: got %h want %h", $time, got, exp);
        end
    endtask : check
    task automatic wb(input logic we, input logic [7:0] a,
            input logic [31:0] d);
        int n;
        @(posedge clock);
        wb_cyc_i <= 1'b1;
        wb_stb_i <= 1'b1;
        wb_we_i <= we;
        wb_sel_i <= lanes;
        wb_adr_i <= a;
        wb_dat_i <= d;
        n = 0;
        do begin
            @(posedge clock);
            n++;
        end while (wb_ack_o !== 1'b1 && n < 20);
        if (wb_ack_o !== 1'b1) begin
            n_fail++;
            $display("MISMATCH at %0t: no ack", $time);
            wrap_up();
        end
        rq = wb_dat_o;
        wb_cyc_i <= 1'b0;
        wb_stb_i <= 1'b0;
    endtask : wb
    task automatic rd(input logic [7:0] a, input logic [31:0] e);
        wb(1'b0, a, 32'h0);
        check(rq, e);
    endtask : rd
    task automatic put(input int b, input logic v);
        @(posedge clock);
        fl[b] <= v;
        repeat (2) @(posedge clock);
        #1;
    endtask : put
    task automatic sp(input logic [15:0] f, input logic [15:0] m,
            input logic [31:0] e);
        @(posedge clock);
        out_freq <= f;
        motor_speed <= m;
        repeat (2) @(posedge clock);
        #1;
        check({29'h0, seen}, e);
    endtask : sp
    task automatic sel3(input logic [7:0] c);
        wb(1'b1, scos_pkg::OFS_SEL3, {24'h0, c});
    endtask : sel3
    task automatic t_level(input logic [7:0] c, input int b, input logic i);
        sel3(c);
        put(b, 1'b1);
        check({29'h0, seen}, i ? 32'h0 : 32'h4);
        put(b, 1'b0);
        check({29'h0, seen}, i ? 32'h4 : 32'h0);
        $display("level test %h done", c);
    endtask : t_level
    task automatic t_reset;
        rd(scos_pkg::OFS_SEL1, 32'h40);
        rd(scos_pkg::OFS_SEL2, 32'h41);
        rd(scos_pkg::OFS_SEL3, 32'h6);
        wb(1'b1, 8'h1C, 32'hFF);
        rd(8'h1C, 32'h0);
        check({29'h0, seen}, 32'h0);
        $display("reset test done");
    endtask : t_reset
    task automatic t_fault;
        sel3(scos_pkg::FN_FAULT);
        put(6, 1'b1);
        put(5, 1'b1);
        check({29'h0, seen}, 32'h0);
        put(6, 1'b0);
        check({29'h0, seen}, 32'h4);
        put(7, 1'b1);
        check({29'h0, seen}, 32'h0);
        put(7, 1'b0);
        put(5, 1'b0);
        put(8, 1'b1);
        check({29'h0, seen}, 32'h0);
        put(8, 1'b0);
        $display("fault test done");
    endtask : t_fault
    task automatic t_speed;
        wb(1'b1, scos_pkg::OFS_ZERO_THR, 32'h100);
        sel3(scos_pkg::FN_ZERO_SPD);
        sp(16'h50, 16'h0, 32'h4);
        sp(16'h100, 16'h0, 32'h4);
        sp(16'h200, 16'h0, 32'h0);
        sp(16'h100, 16'h0, 32'h0);
        sel3(scos_pkg::FN_NOT_ZERO);
        sp(16'h200, 16'h0, 32'h4);
        sp(16'h50, 16'h0, 32'h0);
        $display("speed test done");
    endtask : t_speed
    task automatic t_door;
        wb(1'b1, scos_pkg::OFS_DOOR_THR, 32'h100);
        sel3(scos_pkg::FN_DOOR_ZONE);
        put(2, 1'b1);
        put(3, 1'b1);
        sp(16'h200, 16'h0, 32'h4);
        sp(16'h80, 16'h0, 32'h0);
        sp(16'h200, 16'h0, 32'h4);
        put(3, 1'b0);
        check({29'h0, seen}, 32'h0);
        put(3, 1'b1);
        wb(1'b1, scos_pkg::OFS_CTRL, 32'h1);
        sp(16'h200, 16'h50, 32'h0);
        sp(16'h50, 16'h200, 32'h4);
        put(2, 1'b0);
        check({29'h0, seen}, 32'h0);
        put(3, 1'b0);
        $display("door test done");
    endtask : t_door
    task automatic t_three;
        wb(1'b1, scos_pkg::OFS_SEL1, {24'h0, scos_pkg::FN_UNDERVOLT});
        wb(1'b1, scos_pkg::OFS_SEL2, {24'h0, scos_pkg::FN_RUN});
        sel3(8'h05);
        put(11, 1'b1);
        check({29'h0, seen}, 32'h1);
        rd(scos_pkg::OFS_STATUS, 32'h1);
        put(0, 1'b1);
        check({29'h0, seen}, 32'h3);
        put(15, 1'b1);
        check({29'h0, seen}, 32'h3);
        $display("three output test done");
    endtask : t_three
    task automatic t_lanes;
        lanes = 4'h2;
        wb(1'h1, scos_pkg::OFS_ZERO_THR, 32'h0000_1234);
        rd(scos_pkg::OFS_ZERO_THR, 32'h0000_1200);
        wb(1'h1, scos_pkg::OFS_SEL1, 32'h0000_0000);
        rd(scos_pkg::OFS_SEL1, {24'h0, scos_pkg::FN_UNDERVOLT});
        lanes = 4'h1;
        wb(1'h1, scos_pkg::OFS_ZERO_THR, 32'h0000_5678);
        rd(scos_pkg::OFS_ZERO_THR, 32'h0000_1278);
        rd(scos_pkg::OFS_CTRL, 32'h0000_0001);
        lanes = 4'hF;
        $display("byte lane test done");
    endtask : t_lanes
    task automatic t_rst_mid;
        @(posedge clock);
        srst <= 1'h1;
        repeat (2) @(posedge clock);
        #1;
        check({29'h0, contact_out}, 32'h0);
        @(posedge clock);
        srst <= 1'h0;
        @(posedge clock);
        rd(scos_pkg::OFS_SEL1, {24'h0, scos_pkg::RST_SEL1});
        rd(scos_pkg::OFS_SEL3, {24'h0, scos_pkg::RST_SEL3});
        $display("mid-run reset test done");
    endtask : t_rst_mid
    initial begin
        srst = 1'b1;
        wb_cyc_i = 1'b0;
        wb_stb_i = 1'b0;
        wb_we_i = 1'b0;
        wb_sel_i = 4'h0;
        lanes = 4'hF;
        wb_adr_i = 8'h0;
        wb_dat_i = 32'h0;
        out_freq = 16'h0;
        motor_speed = 16'h0;
        fl = 17'h0;
        n_fail = 0;
        comparisons = 0;
        repeat (16) @(posedge clock);
        srst <= 1'b0;
        repeat (2) @(posedge clock);
        t_reset();
        t_level(scos_pkg::FN_RUN, 0, 1'b0);
        t_level(scos_pkg::FN_RUN, 1, 1'b0);
        t_level(scos_pkg::FN_READY, 4, 1'b0);
        t_level(scos_pkg::FN_UNDERVOLT, 11, 1'b0);
        t_level(scos_pkg::FN_BLOCKED, 12, 1'b0);
        t_level(scos_pkg::FN_REF_LOCAL, 13, 1'b0);
        t_level(scos_pkg::FN_CMD_LOCAL, 14, 1'b0);
        t_level(scos_pkg::FN_MINOR, 8, 1'b0);
        t_level(scos_pkg::FN_FLT_RESET, 9, 1'b0);
        t_level(scos_pkg::FN_REVERSE, 10, 1'b0);
        t_level(scos_pkg::FN_EXT_BLOCK, 15, 1'b1);
        t_level(scos_pkg::FN_REGEN, 16, 1'b0);
        t_fault();
        t_speed();
        t_door();
        t_three();
        t_lanes();
        t_rst_mid();
        wrap_up();
    end
endmodule : scos_tb_top
